/* File: pkg/uoecs_pkg.sv */
// Constants for the OUT endpoint control and status byte.
// Assumes one clock domain and a byte-wide register port.
// Functional notes
// - Writing one to the clear-toggle bit resets the endpoint data toggle to zero.
// - The clear-toggle bit always reads as zero.
// - Writing zero to send-stall ends STALL answers, and send-stall does nothing in isochronous mode.
// - Writing one to the discard bit drops the next unread packet, resets the read pointer and clears packet-ready.
// - The discard bit clears itself once the discard has completed.
// - FIFO-full reads one with two packets held under double buffering, or one packet otherwise.
// - The overrun flag sets when a packet is lost to a full FIFO and stays set until cleared.
// - An OUT token with data sets packet-ready and raises an interrupt; firmware unloads and clears it.
// - While send-stall is one outside isochronous mode every OUT gets STALL, and each STALL sets stall-sent and interrupts.
// - In isochronous mode a CRC-error packet is stored, sets packet-ready, interrupts and sets data-error.
// - In isochronous mode a packet with no room interrupts and sets overrun.
package uoecs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] UOECS_ADDR_CTRL_LOW = 8'h14;
  localparam logic [7:0] UOECS_ADDR_CTRL_HIGH = 8'h15;
  localparam logic [7:0] UOECS_ADDR_INT_STATUS = 8'h16;
  localparam logic [7:0] UOECS_ADDR_INT_MASK = 8'h17;
  localparam logic [7:0] UOECS_RESET_VALUE = 8'h00;
  // ==========================================================
  // Control low byte fields
  localparam int UOECS_BIT_CLEAR_TOGGLE = 7;
  localparam int UOECS_BIT_STALL_SENT = 6;
  localparam int UOECS_BIT_SEND_STALL = 5;
  localparam int UOECS_BIT_DISCARD = 4;
  localparam int UOECS_BIT_DATA_ERROR = 3;
  localparam int UOECS_BIT_OVERRUN = 2;
  localparam int UOECS_BIT_FIFO_FULL = 1;
  localparam int UOECS_BIT_PACKET_READY = 0;
  // ==========================================================
  // Control high byte fields
  localparam int UOECS_BIT_DOUBLE_BUFFER = 7;
  localparam int UOECS_BIT_ISO = 6;
  // ==========================================================
  // Interrupt status fields
  localparam int UOECS_IRQ_PACKET = 0;
  localparam int UOECS_IRQ_STALL = 1;
  localparam int UOECS_IRQ_OVERRUN = 2;
  localparam int UOECS_IRQ_WIDTH = 3;
  // ==========================================================
  // Link answers
  typedef enum logic [2:0] {
    UOECS_RESP_NONE = 3'h0,
    UOECS_RESP_ACK = 3'h1,
    UOECS_RESP_NAK = 3'h2,
    UOECS_RESP_STALL = 3'h4
  } uoecs_resp_t;
endpackage

/* File: hdl/uoecs_occupancy.sv */
// Packet occupancy counter for the OUT FIFO.
// Assumes store and drop are one-cycle pulses on clk.
`timescale 1ns/10ps
module uoecs_occupancy
  import uoecs_pkg::*;
#(
  parameter int COUNT_W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic double_buffer,
  input wire logic store,
  input wire logic drop,
  output logic [COUNT_W-1:0] count,
  output logic full
);
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] limit;

  // ==========================================================
  // Count
  always_comb begin
    count_next = count_reg;
    if (store && !drop) begin
      count_next = count_reg + COUNT_W'(1);
    end else if (drop && !store && count_reg != '0) begin
      count_next = count_reg - COUNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign limit = double_buffer ? COUNT_W'(2) : COUNT_W'(1);
  assign count = count_reg;
  assign full = (count_reg >= limit);
endmodule

/* File: hdl/uoecs_ctrl.sv */
// OUT endpoint control and status byte with interrupt logic.
// Assumes the link side delivers one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
module uoecs_ctrl
  import uoecs_pkg::*;
#(
  parameter int COUNT_W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic out_token,
  input wire logic out_data,
  input wire logic out_crc_error,
  input wire logic fifo_read,
  output logic [2:0] link_resp,
  output logic store_packet,
  output logic data_toggle,
  output logic discard_pulse,
  output logic read_ptr_reset,
  output logic irq
);
  logic stall_sent_reg;
  logic stall_sent_next;
  logic send_stall_reg;
  logic send_stall_next;
  logic discard_reg;
  logic discard_next;
  logic data_error_reg;
  logic data_error_next;
  logic overrun_reg;
  logic overrun_next;
  logic ready_reg;
  logic ready_next;
  logic toggle_reg;
  logic toggle_next;
  logic dbuf_reg;
  logic dbuf_next;
  logic iso_reg;
  logic iso_next;
  logic [UOECS_IRQ_WIDTH-1:0] status_reg;
  logic [UOECS_IRQ_WIDTH-1:0] status_next;
  logic [UOECS_IRQ_WIDTH-1:0] mask_reg;
  logic [UOECS_IRQ_WIDTH-1:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] resp_reg;
  logic [2:0] resp_next;
  logic [UOECS_IRQ_WIDTH-1:0] events;
  logic [COUNT_W-1:0] count;
  logic full;
  logic wr_low;
  logic wr_high;
  logic stalling;
  logic accept;
  logic lost;
  logic drop;
  logic fetch;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================
  // Packet flow
  assign wr_low = reg_write && hit(reg_addr, UOECS_ADDR_CTRL_LOW);
  assign wr_high = reg_write && hit(reg_addr, UOECS_ADDR_CTRL_HIGH);
  assign stalling = send_stall_reg && !iso_reg;
  assign accept = out_token && out_data && !stalling && !full &&
    (!out_crc_error || iso_reg);
  assign lost = out_token && out_data && !stalling && full;
  // A discard acts in the cycle after the request so the bit reads one.
  assign drop = discard_reg && count != '0;
  // Firmware has unloaded the current packet, so its slot is free again.
  assign fetch = fifo_read && ready_reg;

  uoecs_occupancy #(
    .COUNT_W(COUNT_W)
  ) u_occ (
    .clk(clk),
    .resetn(resetn),
    .double_buffer(dbuf_reg),
    .store(accept),
    .drop(drop || fetch),
    .count(count),
    .full(full)
  );

  // ==========================================================
  // Control and status next state
  always_comb begin
    stall_sent_next = stall_sent_reg;
    send_stall_next = send_stall_reg;
    discard_next = discard_reg;
    data_error_next = data_error_reg;
    overrun_next = overrun_reg;
    ready_next = ready_reg;
    toggle_next = toggle_reg;
    dbuf_next = dbuf_reg;
    iso_next = iso_reg;
    // The finished discard is retired first so that a new request written
    // in the same cycle is kept rather than lost.
    if (discard_reg) begin
      discard_next = 1'b0;
      ready_next = 1'b0;
      data_error_next = 1'b0;
    end
    if (wr_low) begin
      if (!reg_wdata[UOECS_BIT_STALL_SENT]) begin
        stall_sent_next = 1'b0;
      end
      if (!reg_wdata[UOECS_BIT_OVERRUN]) begin
        overrun_next = 1'b0;
      end
      send_stall_next = reg_wdata[UOECS_BIT_SEND_STALL];
      if (!reg_wdata[UOECS_BIT_PACKET_READY]) begin
        ready_next = 1'b0;
        data_error_next = 1'b0;
      end
      if (reg_wdata[UOECS_BIT_DISCARD]) begin
        discard_next = 1'b1;
      end
      if (reg_wdata[UOECS_BIT_CLEAR_TOGGLE]) begin
        toggle_next = 1'b0;
      end
    end
    if (wr_high) begin
      dbuf_next = reg_wdata[UOECS_BIT_DOUBLE_BUFFER];
      iso_next = reg_wdata[UOECS_BIT_ISO];
    end
    // A second buffered packet becomes ready once the first is gone.
    if (!ready_reg && !discard_reg && count != '0 && !wr_low) begin
      ready_next = 1'b1;
    end
    // Hardware sets win over a same-cycle software clear.
    if (accept) begin
      if (count == '0 || !ready_reg) begin
        ready_next = 1'b1;
      end
      if (!iso_reg) begin
        toggle_next = ~toggle_reg;
      end
      if (iso_reg && out_crc_error) begin
        data_error_next = 1'b1;
      end
    end
    if (lost) begin
      overrun_next = 1'b1;
    end
    if (out_token && stalling) begin
      stall_sent_next = 1'b1;
    end
  end

  // ==========================================================
  // Interrupts and link answer
  always_comb begin
    events = '0;
    events[UOECS_IRQ_PACKET] = accept;
    events[UOECS_IRQ_STALL] = out_token && stalling;
    events[UOECS_IRQ_OVERRUN] = lost;
    status_next = status_reg;
    mask_next = mask_reg;
    if (reg_write && hit(reg_addr, UOECS_ADDR_INT_STATUS)) begin
      status_next = status_reg & ~reg_wdata[UOECS_IRQ_WIDTH-1:0];
    end
    if (reg_write && hit(reg_addr, UOECS_ADDR_INT_MASK)) begin
      mask_next = reg_wdata[UOECS_IRQ_WIDTH-1:0];
    end
    status_next = status_next | events;
    resp_next = UOECS_RESP_NONE;
    if (out_token) begin
      if (stalling) begin
        resp_next = UOECS_RESP_STALL;
      end else if (accept && !iso_reg) begin
        resp_next = UOECS_RESP_ACK;
      end else if (!iso_reg) begin
        resp_next = UOECS_RESP_NAK;
      end
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rdata_next = '0;
    if (reg_read) begin
      case (reg_addr)
        UOECS_ADDR_CTRL_LOW: begin
          rdata_next[UOECS_BIT_CLEAR_TOGGLE] = 1'b0;
          rdata_next[UOECS_BIT_STALL_SENT] = stall_sent_reg;
          rdata_next[UOECS_BIT_SEND_STALL] = send_stall_reg;
          rdata_next[UOECS_BIT_DISCARD] = discard_reg;
          rdata_next[UOECS_BIT_DATA_ERROR] = data_error_reg;
          rdata_next[UOECS_BIT_OVERRUN] = overrun_reg;
          rdata_next[UOECS_BIT_FIFO_FULL] = full;
          rdata_next[UOECS_BIT_PACKET_READY] = ready_reg;
        end
        UOECS_ADDR_CTRL_HIGH: begin
          rdata_next[UOECS_BIT_DOUBLE_BUFFER] = dbuf_reg;
          rdata_next[UOECS_BIT_ISO] = iso_reg;
        end
        UOECS_ADDR_INT_STATUS: begin
          rdata_next[UOECS_IRQ_WIDTH-1:0] = status_reg;
        end
        UOECS_ADDR_INT_MASK: begin
          rdata_next[UOECS_IRQ_WIDTH-1:0] = mask_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_sent_reg <= 1'b0;
      send_stall_reg <= 1'b0;
      discard_reg <= 1'b0;
      data_error_reg <= 1'b0;
      overrun_reg <= 1'b0;
      ready_reg <= 1'b0;
      toggle_reg <= 1'b0;
      dbuf_reg <= 1'b0;
      iso_reg <= 1'b0;
      status_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= UOECS_RESET_VALUE;
      resp_reg <= UOECS_RESP_NONE;
    end else begin
      stall_sent_reg <= stall_sent_next;
      send_stall_reg <= send_stall_next;
      discard_reg <= discard_next;
      data_error_reg <= data_error_next;
      overrun_reg <= overrun_next;
      ready_reg <= ready_next;
      toggle_reg <= toggle_next;
      dbuf_reg <= dbuf_next;
      iso_reg <= iso_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign link_resp = resp_reg;
  assign store_packet = accept;
  assign data_toggle = toggle_reg;
  assign discard_pulse = drop;
  assign read_ptr_reset = discard_reg;
  assign irq = |(status_reg & mask_reg);
endmodule

/* File: testbench/uoecs_host.sv */
// USB host stand-in issuing OUT tokens with data packets.
// Assumes requests arrive as one-cycle pulses on clk.
`timescale 1ns/10ps
module uoecs_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic send,
  input wire logic bad_crc,
  output logic out_token,
  output logic out_data,
  output logic out_crc_error
);
  // Token and data travel together, so a lone token never occurs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_token <= 1'b0;
      out_data <= 1'b0;
      out_crc_error <= 1'b0;
    end else begin
      out_token <= send;
      out_data <= send;
      out_crc_error <= send & bad_crc;
    end
  end
endmodule

/* File: testbench/uoecs_chk.sv */
// Checker for the OUT endpoint control byte ports.
// Assumes it is bound to uoecs_ctrl on one clock.
`timescale 1ns/10ps
module uoecs_chk
  import uoecs_pkg::*;
#(
  parameter int COUNT_W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic out_token,
  input wire logic out_data,
  input wire logic store_packet,
  input wire logic data_toggle,
  input wire logic read_ptr_reset,
  input wire logic [2:0] link_resp
);
  // ==========================================================
  // Sequences and assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence discard_req;
    reg_write && reg_addr == 8'h14 && reg_wdata[4];
  endsequence
  sequence late_read;
    !reg_write ##1 reg_read && reg_addr == 8'h14;
  endsequence
  rdata_quiet_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (reg_read &&
    !(reg_addr inside {[8'h14:8'h17]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  toggle_read_a: assert property (reg_read && reg_addr == 8'h14 |=>
    !reg_rdata[7]) else $error("clear toggle bit read as one");
  toggle_clear_a: assert property (reg_write && reg_addr == 8'h14 &&
    reg_wdata[7] && !out_token && !$past(out_token) |=> !data_toggle)
    else $error("toggle not cleared");
  discard_ptr_a: assert property (discard_req |->
    ##[1:2] read_ptr_reset) else $error("read pointer not reset");
  discard_self_a: assert property (discard_req ##1 late_read |=>
    !reg_rdata[4]) else $error("discard bit did not clear");
  store_cause_a: assert property (store_packet |->
    out_token && out_data) else $error("store without token");
  resp_pulse_a: assert property (!out_token |=> link_resp == 3'h0)
    else $error("answer without token");
  resp_legal_a: assert property (out_token |=>
    link_resp inside {3'h0, 3'h1, 3'h2, 3'h4}) else $error("bad answer");
endmodule

bind uoecs_ctrl uoecs_chk #(.COUNT_W(COUNT_W)) chk_u (.clk(clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .out_token(out_token), .out_data(out_data),
  .store_packet(store_packet), .data_toggle(data_toggle),
  .read_ptr_reset(read_ptr_reset), .link_resp(link_resp));

/* File: testbench/uoecs_bench.sv */
// Self-checking bench for the OUT endpoint control byte.
// Assumes uoecs_ctrl, its checker and the host stand-in.
`timescale 1ns/10ps
module uoecs_bench
  import uoecs_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic fifo_read = 1'b0, send = 1'b0, bad_crc = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] link_resp;
  logic out_token, out_data, out_crc_error, store_packet, data_toggle, irq;
  logic discard_pulse;
  int bad_count = 0, num_checks = 0, cycles = 0;
  always #50 clk = ~clk;
  uoecs_host host_u (.clk(clk), .resetn(resetn), .send(send),
    .bad_crc(bad_crc), .out_token(out_token), .out_data(out_data),
    .out_crc_error(out_crc_error));
  uoecs_ctrl #(.COUNT_W(2)) dut_u (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .out_token(out_token),
    .out_data(out_data), .out_crc_error(out_crc_error),
    .fifo_read(fifo_read), .link_resp(link_resp),
    .store_packet(store_packet), .data_toggle(data_toggle),
    .discard_pulse(discard_pulse), .read_ptr_reset(), .irq(irq));
  // ==========================================================
  // Bus and compare tasks
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task pkt(input logic c, input logic [2:0] e);
    @(posedge clk);
    send <= 1'b1;
    bad_crc <= c;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 chk("link_resp", {5'h00, e}, {5'h00, link_resp});
    repeat (2) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task t_bulk;
    rd(8'h30, 8'h00);
    wr(8'h17, 8'h07);
    pkt(1'b0, UOECS_RESP_ACK);
    rd(8'h14, 8'h03);
    chk("irq", 8'h01, {7'h00, irq});
    pkt(1'b0, UOECS_RESP_NAK);
    rd(8'h14, 8'h07);
    wr(8'h14, 8'h07);
    rd(8'h14, 8'h07);
    wr(8'h14, 8'h03);
    rd(8'h14, 8'h03);
    rd(8'h16, 8'h05);
    chk("data_toggle", 8'h01, {7'h00, data_toggle});
    wr(8'h16, 8'h05);
    wr(8'h14, 8'h81);
    #1 chk("data_toggle", 8'h00, {7'h00, data_toggle});
    rd(8'h14, 8'h03);
    chk("irq", 8'h00, {7'h00, irq});
    wr(8'h14, 8'h13);
    rd(8'h14, 8'h00);
  endtask
  task t_stall;
    wr(8'h14, 8'h20);
    pkt(1'b0, UOECS_RESP_STALL);
    rd(8'h14, 8'h60);
    rd(8'h16, 8'h02);
    wr(8'h14, 8'h40);
    pkt(1'b0, UOECS_RESP_ACK);
    rd(8'h14, 8'h43);
    @(posedge clk);
    fifo_read <= 1'b1;
    @(posedge clk);
    fifo_read <= 1'b0;
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
  endtask
  task t_double;
    wr(8'h16, 8'h07);
    wr(8'h15, 8'h80);
    pkt(1'b0, UOECS_RESP_ACK);
    rd(8'h14, 8'h01);
    pkt(1'b0, UOECS_RESP_ACK);
    rd(8'h14, 8'h03);
    wr(8'h14, 8'h11);
    #1 chk("discard_pulse", 8'h01, {7'h00, discard_pulse});
    // The buffered packet is promoted one cycle after the discard ends.
    @(posedge clk);
    rd(8'h14, 8'h01);
    wr(8'h14, 8'h11);
    rd(8'h14, 8'h00);
  endtask
  task t_iso;
    wr(8'h16, 8'h07);
    wr(8'h15, 8'h40);
    wr(8'h14, 8'h20);
    pkt(1'b1, UOECS_RESP_NONE);
    rd(8'h14, 8'h2B);
    pkt(1'b0, UOECS_RESP_NONE);
    rd(8'h14, 8'h2F);
    rd(8'h16, 8'h05);
  endtask
  task finish_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang anywhere ends the run well after all scenarios should finish.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h14, 8'h00);
    t_bulk();
    t_stall();
    t_double();
    t_iso();
    finish_test();
  end
endmodule
